// ==== hdl/gpapc_defs.vh ====
// gpapc_defs.vh: register offsets, field masks and reset values of the shared-pin port block
// assumes: included by bare name from every design file of the block
`ifndef GPAPC_DEFS_VH
`define GPAPC_DEFS_VH

// direction registers of the port mode bank
`define GPAPC_DIR_BASE 16'hFF20
`define GPAPC_PORT0_DIR 16'hFF20
`define GPAPC_PORT1_DIR 16'hFF21
`define GPAPC_PORT3_DIR 16'hFF23
`define GPAPC_PORT4_DIR 16'hFF24
`define GPAPC_PORT5_DIR 16'hFF25
`define GPAPC_PORT6_DIR 16'hFF26
`define GPAPC_PORT7_DIR 16'hFF27
`define GPAPC_PORT8_DIR 16'hFF28
`define GPAPC_PORT9_DIR 16'hFF29
`define GPAPC_PORT12_DIR 16'hFF2C
`define GPAPC_PORT13_DIR 16'hFF2D

// output latches and pull-up selects
`define GPAPC_PORT9_LATCH 16'hFF09
`define GPAPC_PORT12_LATCH 16'hFF0C
`define GPAPC_PORT13_LATCH 16'hFF0D
`define GPAPC_PORT12_PULLUP 16'hFF3C
`define GPAPC_PORT13_PULLUP 16'hFF3D

// writable bits of each direction register; all other bits are fixed
`define GPAPC_MASK_PORT0 8'h63
`define GPAPC_MASK_PORT1 8'hFF
`define GPAPC_MASK_NIBBLE 8'h0F
`define GPAPC_MASK_PORT7 8'h7F
`define GPAPC_MASK_PORT8 8'hFF
`define GPAPC_MASK_PORT9 8'h0F
`define GPAPC_MASK_PORT12 8'h1F
`define GPAPC_MASK_PORT13 8'h06

// writable bits of the pull-up select registers
`define GPAPC_PU_MASK_PORT12 8'h01
`define GPAPC_PU_MASK_PORT13 8'h06

// reset values
`define GPAPC_DIR_RESET 8'hFF
`define GPAPC_DIR13_RESET 8'hFE
`define GPAPC_LATCH_RESET 8'h00
`define GPAPC_PULLUP_RESET 8'h00

// converter channel numbers of the analog-shared pins
`define GPAPC_ANALOG_CH_BASE 4'h8

`endif

// ==== hdl/gpapc_pin.v ====
// gpapc_pin.v: one bidirectional port bit with its input synchroniser and read selector
// assumes: dir and latch come from registers on core_clk; pin_in is asynchronous
`timescale 1ns/1ps
`include "gpapc_defs.vh"

module gpapc_pin (
  input wire core_clk,
  input wire reset,
  input wire dir,
  input wire latch,
  input wire drive_allow,
  input wire pullup_sel,
  input wire pin_in,
  output wire pin_out,
  output wire pin_oe_n,
  output wire pullup_en,
  output wire pin_sync,
  output wire read_val
);

  reg meta_ff;
  reg sync_ff;

  // two-stage synchroniser; the first stage feeds only the second
  always @(posedge core_clk) begin
    if (reset) begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
    end else begin
      meta_ff <= pin_in;
      sync_ff <= meta_ff;
    end
  end

  // buffer on only for output mode, dir 0 means output
  assign pin_out = latch;
  assign pin_oe_n = ~(drive_allow & ~dir);
  // pull-up is cut while the bit drives, so it never fights the buffer
  assign pullup_en = pullup_sel & dir & drive_allow;
  assign pin_sync = sync_ff;
  // input mode reads the pin, output mode reads the latch
  assign read_val = dir ? sync_ff : latch;

endmodule // gpapc_pin

// ==== hdl/gpapc_dir_bank.v ====
// gpapc_dir_bank.v: direction registers of the ports outside the shared-pin group
// assumes: word index is the low address nibble above the bank base; strobes from core_clk logic
`timescale 1ns/1ps
`include "gpapc_defs.vh"

module gpapc_dir_bank #(
  parameter DEPTH = 16,
  parameter AW = 4
) (
  input wire core_clk,
  input wire reset,
  input wire [AW-1:0] index,
  input wire byte_wr,
  input wire bit_wr,
  input wire [2:0] bit_idx,
  input wire bit_val,
  input wire [7:0] wdata,
  input wire rd,
  output wire [7:0] rdata,
  output wire [8*DEPTH-1:0] dir_flat
);

  reg [7:0] mem_ff [0:DEPTH-1];
  reg [7:0] rdata_ff;

  // writable bits per word; unused words have none and read as zero
  function [7:0] wmask;
    input [AW-1:0] i;
    begin
      case (i)
        4'h0: wmask = `GPAPC_MASK_PORT0;
        4'h1: wmask = `GPAPC_MASK_PORT1;
        4'h3, 4'h4, 4'h5, 4'h6: wmask = `GPAPC_MASK_NIBBLE;
        4'h7: wmask = `GPAPC_MASK_PORT7;
        4'h8: wmask = `GPAPC_MASK_PORT8;
        default: wmask = 8'h00;
      endcase
    end
  endfunction

  // value a word holds after reset; absent pins stay at it for good
  function [7:0] rstval;
    input [AW-1:0] i;
    begin
      case (i)
        4'h0, 4'h1, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8: rstval = `GPAPC_DIR_RESET;
        default: rstval = 8'h00;
      endcase
    end
  endfunction

  genvar g;
  generate
    for (g = 0; g < DEPTH; g = g + 1) begin : g_word
      wire [31:0] gw = g;
      wire [AW-1:0] gi = gw[AW-1:0];
      wire [7:0] bitsel = 8'h01 << bit_idx;
      wire [7:0] merged = byte_wr ? wdata : ((mem_ff[g] & ~bitsel) | ({8{bit_val}} & bitsel));
      // byte or single-bit write, masked so fixed bits keep their value
      always @(posedge core_clk) begin
        if (reset) begin
          mem_ff[g] <= rstval(gi);
        end else if ((byte_wr | bit_wr) && index == gi) begin
          mem_ff[g] <= (merged & wmask(gi)) | (rstval(gi) & ~wmask(gi));
        end
      end
      assign dir_flat[8*g+7:8*g] = mem_ff[g];
    end
  endgenerate

  // registered read port
  always @(posedge core_clk) begin
    if (reset) begin
      rdata_ff <= 8'h00;
    end else if (rd) begin
      rdata_ff <= mem_ff[index];
    end
  end
  assign rdata = rdata_ff;

endmodule // gpapc_dir_bank

// ==== hdl/gpapc_top.v ====
// gpapc_top.v: analog-shared port, five-bit clock-shared port, third port and the direction bank
// assumes: byte and bit access strobes from the CPU bus on core_clk; pins are asynchronous;
// analog/digital selection, channel select and clock mode arrive already decoded from their owners
// How it works
// - analog port: four bits, per-bit direction
// - digital plus output drives latch to pin
// - analog input converts when channel selected
// - reset leaves analog port analog inputs
// - five-bit port with per-bit direction
// - bit 0 pull-up only as input
// - reset makes five-bit port all inputs
// - clock mode takes bits 1-4 over
// - third port bit 0 always drives latch
// - third port bits 1-2 bidirectional, pull-ups
// - output-only bit low during reset
// - byte and single-bit direction writes
// - direction reset all ones, third FE
// - direction 0 output, 1 input
// - read: pin if input, latch if output
// - reset clears every output latch
`timescale 1ns/1ps
`include "gpapc_defs.vh"

module gpapc_top #(
  parameter ANALOG_BITS = 4,
  parameter FIVE_BITS = 5,
  parameter THIRD_IO_BITS = 2
) (
  input wire core_clk,
  input wire reset,
  input wire [15:0] cpu_addr,
  input wire cpu_wr,
  input wire cpu_bit_wr,
  input wire [2:0] cpu_bit_idx,
  input wire cpu_bit_val,
  input wire [7:0] cpu_wdata,
  input wire cpu_rd,
  output wire [7:0] cpu_rdata,
  input wire [ANALOG_BITS-1:0] pin_analog_digital_config,
  input wire [3:0] converter_channel_select,
  input wire converter_enable,
  input wire clock_main_osc_sel,
  input wire clock_sub_osc_sel,
  input wire [ANALOG_BITS-1:0] analog_pin_in,
  output wire [ANALOG_BITS-1:0] analog_pin_out,
  output wire [ANALOG_BITS-1:0] analog_pin_oe_n,
  output wire [ANALOG_BITS-1:0] analog_input_pin,
  output wire [ANALOG_BITS-1:0] analog_convert_sel,
  input wire [FIVE_BITS-1:0] five_bit_pin_in,
  output wire [FIVE_BITS-1:0] five_bit_pin_out,
  output wire [FIVE_BITS-1:0] five_bit_pin_oe_n,
  output wire pullup_capable_bit_pu_en,
  output wire external_interrupt_in,
  output wire low_voltage_detect_in,
  output wire main_external_clock_in,
  output wire sub_external_clock_in,
  output wire output_only_bit,
  input wire [THIRD_IO_BITS-1:0] third_pin_in,
  output wire [THIRD_IO_BITS-1:0] third_pin_out,
  output wire [THIRD_IO_BITS-1:0] third_pin_oe_n,
  output wire [THIRD_IO_BITS-1:0] third_pin_pu_en,
  output wire [127:0] other_port_dir
);

  reg [7:0] analog_port_direction_ff;
  reg [7:0] five_bit_port_direction_ff;
  reg [7:0] third_port_direction_ff;
  reg [7:0] analog_port_latch_ff;
  reg [7:0] five_bit_port_latch_ff;
  reg [7:0] third_port_latch_ff;
  reg [7:0] five_bit_port_pullup_ff;
  reg [7:0] third_port_pullup_ff;
  reg [7:0] own_rdata_ff;
  reg bank_sel_ff;
  reg [7:0] nxt_own_rdata;

  wire any_wr = cpu_wr | cpu_bit_wr;
  wire [7:0] bit_mask = 8'h01 << cpu_bit_idx;
  wire [7:0] bank_rdata;
  wire bank_hit;
  wire [ANALOG_BITS-1:0] analog_read;
  wire [FIVE_BITS-1:0] five_read;
  wire [FIVE_BITS-1:0] five_sync;
  wire [FIVE_BITS-1:0] five_allow;
  wire [THIRD_IO_BITS-1:0] third_read;
  wire [THIRD_IO_BITS-1:0] third_sync;

  // byte write replaces the word, bit write changes one bit; fixed bits forced back
  function [7:0] wr_merge;
    input [7:0] old;
    input [7:0] mask;
    input [7:0] fixv;
    input byte_op;
    input [7:0] wdata;
    input [7:0] bsel;
    input bval;
    reg [7:0] merged;
    begin
      merged = byte_op ? wdata : ((old & ~bsel) | ({8{bval}} & bsel));
      wr_merge = (merged & mask) | (fixv & ~mask);
    end
  endfunction

  // direction bank for the ports outside this group, words at base + low nibble
  assign bank_hit = (cpu_addr[15:4] == `GPAPC_DIR_BASE >> 4) &&
    (cpu_addr[3:0] <= 4'h8) && (cpu_addr[3:0] != 4'h2);

  gpapc_dir_bank #(
    .DEPTH(16),
    .AW(4)
  ) u_dir_bank (
    .core_clk(core_clk),
    .reset(reset),
    .index(cpu_addr[3:0]),
    .byte_wr(cpu_wr & bank_hit),
    .bit_wr(cpu_bit_wr & bank_hit),
    .bit_idx(cpu_bit_idx),
    .bit_val(cpu_bit_val),
    .wdata(cpu_wdata),
    .rd(cpu_rd & bank_hit),
    .rdata(bank_rdata),
    .dir_flat(other_port_dir)
  );

  // direction registers of the three ports kept here because the pins read them every cycle
  always @(posedge core_clk) begin
    if (reset) begin
      analog_port_direction_ff <= `GPAPC_DIR_RESET;
      five_bit_port_direction_ff <= `GPAPC_DIR_RESET;
      third_port_direction_ff <= `GPAPC_DIR13_RESET;
    end else if (any_wr) begin
      if (cpu_addr == `GPAPC_PORT9_DIR) begin
        analog_port_direction_ff <= wr_merge(analog_port_direction_ff, `GPAPC_MASK_PORT9,
          `GPAPC_DIR_RESET, cpu_wr, cpu_wdata, bit_mask, cpu_bit_val);
      end
      if (cpu_addr == `GPAPC_PORT12_DIR) begin
        five_bit_port_direction_ff <= wr_merge(five_bit_port_direction_ff, `GPAPC_MASK_PORT12,
          `GPAPC_DIR_RESET, cpu_wr, cpu_wdata, bit_mask, cpu_bit_val);
      end
      if (cpu_addr == `GPAPC_PORT13_DIR) begin
        third_port_direction_ff <= wr_merge(third_port_direction_ff, `GPAPC_MASK_PORT13,
          `GPAPC_DIR13_RESET, cpu_wr, cpu_wdata, bit_mask, cpu_bit_val);
      end
    end
  end

  // output latches and pull-up selects; latches clear on reset
  always @(posedge core_clk) begin
    if (reset) begin
      analog_port_latch_ff <= `GPAPC_LATCH_RESET;
      five_bit_port_latch_ff <= `GPAPC_LATCH_RESET;
      third_port_latch_ff <= `GPAPC_LATCH_RESET;
      five_bit_port_pullup_ff <= `GPAPC_PULLUP_RESET;
      third_port_pullup_ff <= `GPAPC_PULLUP_RESET;
    end else if (any_wr) begin
      if (cpu_addr == `GPAPC_PORT9_LATCH) begin
        analog_port_latch_ff <= wr_merge(analog_port_latch_ff, `GPAPC_MASK_PORT9,
          8'h00, cpu_wr, cpu_wdata, bit_mask, cpu_bit_val);
      end
      if (cpu_addr == `GPAPC_PORT12_LATCH) begin
        five_bit_port_latch_ff <= wr_merge(five_bit_port_latch_ff, `GPAPC_MASK_PORT12,
          8'h00, cpu_wr, cpu_wdata, bit_mask, cpu_bit_val);
      end
      if (cpu_addr == `GPAPC_PORT13_LATCH) begin
        third_port_latch_ff <= wr_merge(third_port_latch_ff, 8'h07,
          8'h00, cpu_wr, cpu_wdata, bit_mask, cpu_bit_val);
      end
      if (cpu_addr == `GPAPC_PORT12_PULLUP) begin
        five_bit_port_pullup_ff <= wr_merge(five_bit_port_pullup_ff, `GPAPC_PU_MASK_PORT12,
          8'h00, cpu_wr, cpu_wdata, bit_mask, cpu_bit_val);
      end
      if (cpu_addr == `GPAPC_PORT13_PULLUP) begin
        third_port_pullup_ff <= wr_merge(third_port_pullup_ff, `GPAPC_PU_MASK_PORT13,
          8'h00, cpu_wr, cpu_wdata, bit_mask, cpu_bit_val);
      end
    end
  end

  // analog-shared port: buffer only in digital mode; analog plus output stays off, being prohibited
  genvar a;
  generate
    for (a = 0; a < ANALOG_BITS; a = a + 1) begin : g_analog
      wire digital = pin_analog_digital_config[a]; // zero at reset keeps the pin analog
      gpapc_pin u_pin (
        .core_clk(core_clk),
        .reset(reset),
        .dir(analog_port_direction_ff[a]),
        .latch(analog_port_latch_ff[a]),
        .drive_allow(digital),
        .pullup_sel(1'b0),
        .pin_in(analog_pin_in[a]),
        .pin_out(analog_pin_out[a]),
        .pin_oe_n(analog_pin_oe_n[a]),
        .pullup_en(),
        .pin_sync(),
        .read_val(analog_read[a])
      );
      // an analog input reaches the converter only when the channel select names it
      assign analog_input_pin[a] = ~digital & analog_port_direction_ff[a];
      assign analog_convert_sel[a] = converter_enable & ~digital & analog_port_direction_ff[a] &
        (converter_channel_select == `GPAPC_ANALOG_CH_BASE + a);
    end
  endgenerate

  // clock mode owns bits 1-2 (main) and 3-4 (sub) whatever direction and latch say
  assign five_allow = {~clock_sub_osc_sel, ~clock_sub_osc_sel,
    ~clock_main_osc_sel, ~clock_main_osc_sel, 1'b1};

  genvar f;
  generate
    for (f = 0; f < FIVE_BITS; f = f + 1) begin : g_five
      gpapc_pin u_pin (
        .core_clk(core_clk),
        .reset(reset),
        .dir(five_bit_port_direction_ff[f]),
        .latch(five_bit_port_latch_ff[f]),
        .drive_allow(five_allow[f]),
        .pullup_sel(five_bit_port_pullup_ff[f]), // only bit 0 is writable
        .pin_in(five_bit_pin_in[f]),
        .pin_out(five_bit_pin_out[f]),
        .pin_oe_n(five_bit_pin_oe_n[f]),
        .pullup_en(),
        .pin_sync(five_sync[f]),
        .read_val(five_read[f])
      );
    end
  endgenerate

  // bit 0 pull-up only while input; its synchronised level feeds interrupt and voltage detect
  assign pullup_capable_bit_pu_en = five_bit_port_pullup_ff[0] & five_bit_port_direction_ff[0];
  assign external_interrupt_in = five_sync[0];
  assign low_voltage_detect_in = five_sync[0];
  // external clocks pass straight to the clock generator; resynchronising them would ruin them
  assign main_external_clock_in = clock_main_osc_sel & five_bit_pin_in[2];
  assign sub_external_clock_in = clock_sub_osc_sel & five_bit_pin_in[4];

  // output-only bit forced low combinationally so it is low even before the first reset edge
  assign output_only_bit = third_port_latch_ff[0] & ~reset;

  genvar t;
  generate
    for (t = 0; t < THIRD_IO_BITS; t = t + 1) begin : g_third
      gpapc_pin u_pin (
        .core_clk(core_clk),
        .reset(reset),
        .dir(third_port_direction_ff[t+1]),
        .latch(third_port_latch_ff[t+1]),
        .drive_allow(1'b1),
        .pullup_sel(third_port_pullup_ff[t+1]),
        .pin_in(third_pin_in[t]),
        .pin_out(third_pin_out[t]),
        .pin_oe_n(third_pin_oe_n[t]),
        .pullup_en(third_pin_pu_en[t]),
        .pin_sync(third_sync[t]),
        .read_val(third_read[t])
      );
    end
  endgenerate

  // read mux for the registers held here; unmapped addresses read zero
  always @* begin
    nxt_own_rdata = 8'h00;
    case (cpu_addr)
      `GPAPC_PORT9_DIR: nxt_own_rdata = analog_port_direction_ff;
      `GPAPC_PORT12_DIR: nxt_own_rdata = five_bit_port_direction_ff;
      `GPAPC_PORT13_DIR: nxt_own_rdata = third_port_direction_ff;
      `GPAPC_PORT9_LATCH: nxt_own_rdata = {4'h0, analog_read};
      `GPAPC_PORT12_LATCH: nxt_own_rdata = {3'h0, five_read};
      `GPAPC_PORT13_LATCH: nxt_own_rdata = {5'h00, third_read, third_port_latch_ff[0]};
      `GPAPC_PORT12_PULLUP: nxt_own_rdata = five_bit_port_pullup_ff;
      `GPAPC_PORT13_PULLUP: nxt_own_rdata = third_port_pullup_ff;
      default: nxt_own_rdata = 8'h00;
    endcase
  end

  // read data valid the cycle after the read strobe, held until the next read
  always @(posedge core_clk) begin
    if (reset) begin
      own_rdata_ff <= 8'h00;
      bank_sel_ff <= 1'b0;
    end else if (cpu_rd) begin
      own_rdata_ff <= nxt_own_rdata;
      bank_sel_ff <= bank_hit;
    end
  end

  assign cpu_rdata = bank_sel_ff ? bank_rdata : own_rdata_ff;

endmodule // gpapc_top

// ==== tb/gpapc_top_checker.sv ====
// gpapc_top_checker.sv: port-level assertions for the shared-pin port block
// assumes: bound into gpapc_top; one core_clk domain with a synchronous active-high reset
`timescale 1ns/1ps
`include "gpapc_defs.vh"

module gpapc_top_checker #(
  parameter ANALOG_BITS = 4,
  parameter FIVE_BITS = 5,
  parameter THIRD_IO_BITS = 2
) (
  input wire core_clk,
  input wire reset,
  input wire [15:0] cpu_addr,
  input wire cpu_wr,
  input wire cpu_bit_wr,
  input wire [2:0] cpu_bit_idx,
  input wire cpu_bit_val,
  input wire [7:0] cpu_wdata,
  input wire cpu_rd,
  input wire [7:0] cpu_rdata,
  input wire [ANALOG_BITS-1:0] pin_analog_digital_config,
  input wire clock_main_osc_sel,
  input wire clock_sub_osc_sel,
  input wire [ANALOG_BITS-1:0] analog_pin_out,
  input wire [ANALOG_BITS-1:0] analog_pin_oe_n,
  input wire [FIVE_BITS-1:0] five_bit_pin_oe_n,
  input wire pullup_capable_bit_pu_en,
  input wire output_only_bit,
  input wire [THIRD_IO_BITS-1:0] third_pin_oe_n,
  input wire [THIRD_IO_BITS-1:0] third_pin_pu_en
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  // single-cycle write triggers
  sequence s_dir9_byte;
    cpu_wr && cpu_addr == `GPAPC_PORT9_DIR && &pin_analog_digital_config;
  endsequence
  sequence s_dir12_bit0;
    cpu_bit_wr && !cpu_wr && cpu_addr == `GPAPC_PORT12_DIR && cpu_bit_idx == 3'h0;
  endsequence
  sequence s_latch13_byte;
    cpu_wr && cpu_addr == `GPAPC_PORT13_LATCH;
  endsequence

  // reset itself must be watched here, so this one is never disabled
  property p_oo_low;
    @(posedge core_clk) disable iff (1'b0) reset |-> !output_only_bit;
  endproperty
  property p_reset_vals;
    $past(reset) |-> &analog_pin_oe_n && &five_bit_pin_oe_n && &third_pin_oe_n && !(|analog_pin_out);
  endproperty
  property p_dir9_byte;
    s_dir9_byte |=> analog_pin_oe_n == $past(cpu_wdata[ANALOG_BITS-1:0]);
  endproperty
  property p_dir12_bit0;
    s_dir12_bit0 |=> five_bit_pin_oe_n[0] == $past(cpu_bit_val);
  endproperty
  property p_oo_latch;
    s_latch13_byte |=> output_only_bit == $past(cpu_wdata[0]);
  endproperty
  // one cycle of grace for a mode change, then clock pins must not drive
  property p_clock_pins;
    (clock_main_osc_sel && $past(clock_main_osc_sel) |-> five_bit_pin_oe_n[2:1] == 2'h3) and
    (clock_sub_osc_sel && $past(clock_sub_osc_sel) |-> five_bit_pin_oe_n[4:3] == 2'h3);
  endproperty
  property p_analog_gate;
    !(|(~analog_pin_oe_n & ~pin_analog_digital_config & ~$past(pin_analog_digital_config)));
  endproperty
  property p_pu_input;
    !(pullup_capable_bit_pu_en && !five_bit_pin_oe_n[0]) && !(|(third_pin_pu_en & ~third_pin_oe_n));
  endproperty
  property p_rd13;
    cpu_rd && cpu_addr == `GPAPC_PORT13_DIR |=> cpu_rdata[0] == 1'b0 && cpu_rdata[7:3] == 5'h1F;
  endproperty
  property p_rd_hold;
    !cpu_rd |=> $stable(cpu_rdata);
  endproperty

  a_oo_low: assert property (p_oo_low) else $error("output-only bit high in reset");
  a_reset_vals: assert property (p_reset_vals) else $error("pins not idle after reset");
  a_dir9_byte: assert property (p_dir9_byte) else $error("analog port direction write lost");
  a_dir12_bit0: assert property (p_dir12_bit0) else $error("five-bit single-bit write lost");
  a_oo_latch: assert property (p_oo_latch) else $error("output-only bit not latch");
  a_clock_pins: assert property (p_clock_pins) else $error("clock pin driven");
  a_analog_gate: assert property (p_analog_gate) else $error("analog pin driven");
  a_pu_input: assert property (p_pu_input) else $error("pull-up on output bit");
  a_rd13: assert property (p_rd13) else $error("third direction read wrong");
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved without read");
endmodule // gpapc_top_checker

bind gpapc_top gpapc_top_checker #(.ANALOG_BITS(ANALOG_BITS), .FIVE_BITS(FIVE_BITS), .THIRD_IO_BITS(THIRD_IO_BITS))
  gpapc_top_checker_i (.core_clk(core_clk), .reset(reset), .cpu_addr(cpu_addr), .cpu_wr(cpu_wr),
  .cpu_bit_wr(cpu_bit_wr), .cpu_bit_idx(cpu_bit_idx), .cpu_bit_val(cpu_bit_val), .cpu_wdata(cpu_wdata),
  .cpu_rd(cpu_rd), .cpu_rdata(cpu_rdata), .pin_analog_digital_config(pin_analog_digital_config),
  .clock_main_osc_sel(clock_main_osc_sel), .clock_sub_osc_sel(clock_sub_osc_sel),
  .analog_pin_out(analog_pin_out), .analog_pin_oe_n(analog_pin_oe_n), .five_bit_pin_oe_n(five_bit_pin_oe_n),
  .pullup_capable_bit_pu_en(pullup_capable_bit_pu_en), .output_only_bit(output_only_bit),
  .third_pin_oe_n(third_pin_oe_n), .third_pin_pu_en(third_pin_pu_en));

// ==== tb/gpapc_board.sv ====
// gpapc_board.sv: board-side model of one pin group: outside drivers, pull-ups, open lines
// assumes: oe_n low means the block drives; the bench sets drv_en/drv_val after a clock edge
`timescale 1ns/1ps

module gpapc_board #(
  parameter W = 4
) (
  input wire core_clk,
  input wire [W-1:0] pin_out,
  input wire [W-1:0] pin_oe_n,
  input wire [W-1:0] pu_en,
  input wire [W-1:0] drv_en,
  input wire [W-1:0] drv_val,
  output logic [W-1:0] level
);
  logic [W-1:0] float_ff = {W{1'b0}};
  // an open line flips every cycle so nothing can rely on a stale level
  always @(posedge core_clk) float_ff <= ~float_ff;
  // block buffer first, then the outside driver, then the pull-up
  always_comb begin
    for (int i = 0; i < W; i++) begin
      if (!pin_oe_n[i]) level[i] = pin_out[i];
      else if (drv_en[i]) level[i] = drv_val[i];
      else if (pu_en[i]) level[i] = 1'b1;
      else level[i] = float_ff[i];
    end
  end
endmodule // gpapc_board

// ==== tb/test_gpapc_top.sv ====
// test_gpapc_top.sv: directed scenarios for the shared-pin port block
// assumes: design and checker compiled first; a board model stands on every pin group
`timescale 1ns/1ps
`include "gpapc_defs.vh"
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_errors++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end

module test_gpapc_top;
  logic core_clk = 1'b0, reset = 1'b1, cpu_wr = 1'b0, cpu_bit_wr = 1'b0, cpu_bit_val = 1'b0, cpu_rd = 1'b0;
  logic [15:0] cpu_addr = 16'h0000;
  logic [7:0] cpu_wdata = 8'h00;
  logic [2:0] cpu_bit_idx = 3'h0;
  logic [3:0] dig_cfg = 4'h0, ch_sel = 4'h0, a_den = 4'h0, a_dv = 4'h0;
  logic conv_en = 1'b0, main_sel = 1'b0, sub_sel = 1'b0;
  logic [4:0] f_den = 5'h00, f_dv = 5'h00;
  logic [1:0] t_den = 2'h0, t_dv = 2'h0;
  wire [7:0] cpu_rdata;
  wire [3:0] a_in, a_out, a_oe_n, a_ana, a_conv;
  wire [4:0] f_in, f_out, f_oe_n;
  wire [1:0] t_in, t_out, t_oe_n, t_pu;
  wire f_pu, oo, mclk, sclk, irq, lvd;
  wire [127:0] bank;
  int n_errors = 0, n_checks = 0;

  gpapc_top gpapc_top_i (.core_clk(core_clk), .reset(reset), .cpu_addr(cpu_addr), .cpu_wr(cpu_wr),
    .cpu_bit_wr(cpu_bit_wr), .cpu_bit_idx(cpu_bit_idx), .cpu_bit_val(cpu_bit_val), .cpu_wdata(cpu_wdata),
    .cpu_rd(cpu_rd), .cpu_rdata(cpu_rdata), .pin_analog_digital_config(dig_cfg),
    .converter_channel_select(ch_sel), .converter_enable(conv_en), .clock_main_osc_sel(main_sel),
    .clock_sub_osc_sel(sub_sel), .analog_pin_in(a_in), .analog_pin_out(a_out), .analog_pin_oe_n(a_oe_n),
    .analog_input_pin(a_ana), .analog_convert_sel(a_conv), .five_bit_pin_in(f_in), .five_bit_pin_out(f_out),
    .five_bit_pin_oe_n(f_oe_n), .pullup_capable_bit_pu_en(f_pu), .external_interrupt_in(irq),
    .low_voltage_detect_in(lvd), .main_external_clock_in(mclk), .sub_external_clock_in(sclk),
    .output_only_bit(oo), .third_pin_in(t_in), .third_pin_out(t_out), .third_pin_oe_n(t_oe_n),
    .third_pin_pu_en(t_pu), .other_port_dir(bank));
  gpapc_board #(.W(4)) board_analog (.core_clk(core_clk), .pin_out(a_out), .pin_oe_n(a_oe_n), .pu_en(4'h0),
    .drv_en(a_den), .drv_val(a_dv), .level(a_in));
  gpapc_board #(.W(5)) board_five (.core_clk(core_clk), .pin_out(f_out), .pin_oe_n(f_oe_n),
    .pu_en({4'h0, f_pu}), .drv_en(f_den), .drv_val(f_dv), .level(f_in));
  gpapc_board #(.W(2)) board_third (.core_clk(core_clk), .pin_out(t_out), .pin_oe_n(t_oe_n), .pu_en(t_pu),
    .drv_en(t_den), .drv_val(t_dv), .level(t_in));

  // 25 ns clock; every bench change lands 1 ns after a rising edge
  initial begin
    forever #12.5 core_clk = ~core_clk;
  end
  task tick;
    @(posedge core_clk);
    #1;
  endtask
  task wr(input logic [15:0] a, input logic [7:0] d);
    tick; cpu_addr = a; cpu_wdata = d; cpu_wr = 1'b1;
    tick; cpu_wr = 1'b0;
  endtask
  task bw(input logic [15:0] a, input logic [2:0] i, input logic v);
    tick; cpu_addr = a; cpu_bit_idx = i; cpu_bit_val = v; cpu_bit_wr = 1'b1;
    tick; cpu_bit_wr = 1'b0;
  endtask
  task rd_chk(input logic [15:0] a, input logic [7:0] e);
    tick; cpu_addr = a; cpu_rd = 1'b1;
    tick; cpu_rd = 1'b0;
    `CHK(cpu_rdata, e)
  endtask

  task t_reset;
    logic [15:0] regs [0:10] = '{16'hFF20, 16'hFF21, 16'hFF23, 16'hFF24, 16'hFF25, 16'hFF26, 16'hFF27,
      16'hFF28, 16'hFF29, 16'hFF2C, 16'hFF2D};
    `CHK({a_ana, a_out, f_out, oo}, {4'hF, 4'h0, 5'h00, 1'b0})
    `CHK({a_oe_n, f_oe_n, t_oe_n}, {4'hF, 5'h1F, 2'h3})
    for (int k = 0; k < 11; k++) rd_chk(regs[k], regs[k] == 16'hFF2D ? 8'hFE : 8'hFF);
    rd_chk(16'hFF2A, 8'h00);
  endtask
  task t_dir_access;
    wr(16'hFF21, 8'h5A); rd_chk(16'hFF21, 8'h5A);
    `CHK(bank[15:8], 8'h5A)
    wr(16'hFF20, 8'h00); rd_chk(16'hFF20, 8'h9C);
    bw(16'hFF29, 3'h5, 1'b0); rd_chk(16'hFF29, 8'hFF);
    wr(16'hFF2D, 8'h00); rd_chk(16'hFF2D, 8'hF8);
    wr(16'hFF2D, 8'hFF); rd_chk(16'hFF2D, 8'hFE);
  endtask
  task t_analog;
    tick; dig_cfg = 4'hF; // digital pins allocated from the low bit up
    wr(16'hFF09, 8'h0A); wr(16'hFF29, 8'hF0);
    `CHK({a_oe_n, a_out}, {4'h0, 4'hA})
    rd_chk(16'hFF09, 8'h0A);
    bw(16'hFF29, 3'h1, 1'b1); a_den = 4'h2; a_dv = 4'h0;
    `CHK(a_oe_n, 4'h2)
    repeat (3) tick;
    rd_chk(16'hFF09, 8'h08);
    a_den = 4'h0; wr(16'hFF29, 8'hFF);
    // analog inputs stay in input mode; analog with output is a setting software must avoid
    tick; dig_cfg = 4'h0; ch_sel = 4'h9; conv_en = 1'b1;
    tick;
    `CHK({a_oe_n, a_ana, a_conv}, {4'hF, 4'hF, 4'h2})
    tick; conv_en = 1'b0; #1;
    `CHK(a_conv, 4'h0)
  endtask
  task t_five;
    bw(16'hFF2C, 3'h0, 1'b0); `CHK(f_oe_n, 5'h1E)
    bw(16'hFF0C, 3'h0, 1'b1); `CHK(f_out[0], 1'b1)
    wr(16'hFF3C, 8'h01); `CHK(f_pu, 1'b0)
    bw(16'hFF2C, 3'h0, 1'b1); `CHK(f_pu, 1'b1)
    f_den = 5'h1E; f_dv = 5'h14;
    repeat (3) tick;
    rd_chk(16'hFF0C, 8'h15);
    `CHK({irq, lvd}, 2'h3)
    f_den = 5'h00; wr(16'hFF2C, 8'h00);
    main_sel = 1'b1; sub_sel = 1'b1;
    tick; tick;
    `CHK(f_oe_n, 5'h1E)
    f_den = 5'h14; f_dv = 5'h14; #1;
    `CHK({mclk, sclk}, 2'h3)
    tick; main_sel = 1'b0; sub_sel = 1'b0; f_den = 5'h00;
    wr(16'hFF2C, 8'hFF);
  endtask
  task t_third;
    wr(16'hFF0D, 8'h07); `CHK(oo, 1'b1)
    bw(16'hFF2D, 3'h1, 1'b0); `CHK({t_oe_n, t_out[0]}, 3'h5)
    wr(16'hFF3D, 8'h06); `CHK(t_pu, 2'h2)
    tick; reset = 1'b1; #1;
    `CHK(oo, 1'b0)
    tick; tick; reset = 1'b0;
    `CHK({oo, t_oe_n, t_pu}, 5'h0C)
  endtask

  // single exit point of the run
  task report_and_stop;
    $display("checks=%0d errors=%0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // a hang counts as a mismatch
  initial begin
    repeat (5000) @(posedge core_clk);
    n_errors++;
    report_and_stop;
  end
  initial begin
    repeat (20) @(posedge core_clk);
    #1 reset = 1'b0;
    t_reset; t_dir_access; t_analog; t_five; t_third;
    report_and_stop;
  end
endmodule // test_gpapc_top
